// ### logic/nvpl_top.sv
// Programming and verify access path to the on-chip non-volatile memory.
`timescale 1ns/100ps
module nvpl_top
    import nvpl_pkg::*;
#(
    parameter int PULSE_CYC = PROG_PULSE_CYC
)
(
    input  wire logic       MCLK_I,
    input  wire logic       ARST_N_I,
    input  wire logic       CE_I,
    input  wire logic [1:0] VARIANT_I,
    input  wire logic       CHIP_RESET_I,
    input  wire logic       CODE_FETCH_STROBE_N_I,
    input  wire logic       ADDR_LATCH_PROG_PULSE_N_I,
    input  wire logic       EXT_ACCESS_PROG_SUPPLY_I,
    input  wire logic [7:0] PORT_ZERO_I,
    input  wire logic [7:0] PORT_ONE_ADDR_HIGH_I,
    input  wire logic [7:0] PORT_THREE_ADDR_LOW_I,
    input  wire logic [7:0] PORT_TWO_DATA_I,
    output logic      [7:0] PORT_TWO_DATA_O,
    output logic            PORT_TWO_DATA_OE_O,
    output logic      [1:0] LOCK_LEVEL_O,
    output logic      [2:0] LOCK_LEVEL_BITS_O,
    output logic      [7:0] CONFIG_BYTE_LOW_O,
    output logic      [7:0] CONFIG_BYTE_HIGH_O,
    output logic            INT_EXEC_EN_O,
    output logic            EXT_EXEC_EN_O,
    output logic            CODE_TABLE_READ_EN_O,
    output logic            PROG_DONE_O,
    output logic            PROG_REFUSED_O
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    nvpl_req_t        req;
    nvpl_var_t        var_r;
    nvpl_pst_t        pst_r;
    logic             strap_done_r;
    logic [PCNT_W-1:0] pcnt_r;
    logic [2:0]       lock_r;
    logic [7:0]       cfg_lo_r;
    logic [7:0]       cfg_hi_r;
    logic [1:0]       lvl;
    logic             prog_sel;
    logic             vfy_sel;
    logic             commit;
    logic             code_we;
    logic             key_we;
    logic             cfg_we;
    logic             lock_we;
    logic             any_we;
    logic             has_code;
    logic [7:0]       code_rd;
    logic [7:0]       key_rd;
    logic             vfy_v_r;
    logic [7:0]       vmode_r;
    logic [15:0]      vaddr_r;
    logic [7:0]       vfy_byte;

    // Port pins gathered into one request word.
    assign req      = '{mode: PORT_ZERO_I,
                        addr: {PORT_ONE_ADDR_HIGH_I, PORT_THREE_ADDR_LOW_I},
                        data: PORT_TWO_DATA_I};
    assign lvl      = lock_level(lock_r, var_r);
    assign has_code = (var_r == VAR_EPROM) || (var_r == VAR_OTP);
    assign prog_sel = CHIP_RESET_I && !CODE_FETCH_STROBE_N_I && EXT_ACCESS_PROG_SUPPLY_I;
    // Verify needs the supply pin low; port two stays driven for two cycles after verify deselects.
    assign vfy_sel  = CHIP_RESET_I && !CODE_FETCH_STROBE_N_I && ADDR_LATCH_PROG_PULSE_N_I &&
                      !EXT_ACCESS_PROG_SUPPLY_I;

    // ****************************************************************
    // Variant strap
    // ****************************************************************
    // The strap is caught on the first enabled edge after release, never by the reset.
    always_ff @(posedge MCLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            var_r        <= VAR_EPROM;
            strap_done_r <= 1'b0;
        end
        else if (CE_I && !strap_done_r)
        begin
            var_r        <= nvpl_var_t'(VARIANT_I);
            strap_done_r <= 1'b1;
        end
    end

    // ****************************************************************
    // Programming pulse sequencer
    // ****************************************************************
    // A write fires once when the pulse has lasted its full width; a short pulse
    // writes nothing, and a long one cannot write twice until the pin rises.
    assign commit = (pst_r == PST_PULSE) && prog_sel && !ADDR_LATCH_PROG_PULSE_N_I &&
                    (pcnt_r == PCNT_W'(PULSE_CYC - 1));

    always_ff @(posedge MCLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            pst_r  <= PST_IDLE;
            pcnt_r <= '0;
        end
        else if (CE_I)
        begin
            case (pst_r)
                PST_IDLE:
                begin
                    pcnt_r <= '0;
                    if (prog_sel && !ADDR_LATCH_PROG_PULSE_N_I)
                        pst_r <= PST_PULSE;
                end
                PST_PULSE:
                begin
                    pcnt_r <= pcnt_r + 1'b1;
                    if (!prog_sel || ADDR_LATCH_PROG_PULSE_N_I)
                        pst_r <= PST_IDLE;
                    else if (commit)
                        pst_r <= PST_HOLD;
                end
                PST_HOLD:
                begin
                    if (ADDR_LATCH_PROG_PULSE_N_I || !prog_sel)
                        pst_r <= PST_IDLE;
                end
                default:
                    pst_r <= PST_IDLE;
            endcase
        end
    end

    // Target decode; signature addresses have no write path at all.
    assign code_we = commit && has_code && (lvl == 2'd0) &&
                     (req.mode == MODE_PRG_CODE) && (req.addr <= ADDR_CODE_LAST);
    assign key_we  = commit && has_code && (lvl == 2'd0) &&
                     (req.mode == MODE_PRG_KEY) && (req.addr <= ADDR_KEY_LAST);
    assign cfg_we  = commit && has_code && (lvl == 2'd0) && (req.mode == MODE_PRG_CFG) &&
                     ((req.addr == ADDR_CFG_LOW) || (req.addr == ADDR_CFG_HIGH));
    assign lock_we = commit && has_code && (req.mode == MODE_PRG_LOCK) &&
                     (req.addr >= ADDR_LB0) && (req.addr <= ADDR_LB2);
    assign any_we  = code_we || key_we || cfg_we || lock_we;

    // ****************************************************************
    // Storage
    // ****************************************************************
    nvpl_mem #(.DEPTH(CODE_DEPTH), .AW(CODE_AW)) u_code
    (
        .clk_i   (MCLK_I),
        .ce_i    (CE_I),
        .we_i    (code_we),
        .addr_i  (req.addr[CODE_AW-1:0]),
        .wdata_i (req.data),
        .rdata_o (code_rd)
    );

    nvpl_mem #(.DEPTH(KEY_DEPTH), .AW(KEY_AW)) u_key
    (
        .clk_i   (MCLK_I),
        .ce_i    (CE_I),
        .we_i    (key_we),
        .addr_i  (req.addr[KEY_AW-1:0]),
        .wdata_i (req.data),
        .rdata_o (key_rd)
    );

    // Configuration bytes and lock flags; data is ignored for lock bits.
    always_ff @(posedge MCLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            cfg_lo_r <= CFG_RST;
            cfg_hi_r <= CFG_RST;
            lock_r   <= LOCK_RST;
        end
        else if (CE_I)
        begin
            if (cfg_we && (req.addr == ADDR_CFG_LOW))
                cfg_lo_r <= cfg_lo_r & req.data;
            if (cfg_we && (req.addr == ADDR_CFG_HIGH))
                cfg_hi_r <= cfg_hi_r & req.data;
            if (lock_we)
                lock_r[req.addr[1:0] - 2'd1] <= 1'b1;
        end
    end

    // ****************************************************************
    // Verify read path
    // ****************************************************************
    // Stage one aligns the request with the memory read data.
    always_ff @(posedge MCLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            vfy_v_r <= 1'b0;
            vmode_r <= 8'h00;
            vaddr_r <= 16'h0000;
        end
        else if (CE_I)
        begin
            vfy_v_r <= vfy_sel;
            vmode_r <= req.mode;
            vaddr_r <= req.addr;
        end
    end

    // Unreadable or absent areas answer with the erased pattern.
    always_comb
    begin
        vfy_byte = ERASED_BYTE;
        if (vmode_r == MODE_VFY_SIG)
        begin
            if (vaddr_r == ADDR_SIG_0)
                vfy_byte = SIG_BYTE_0;
            else if (vaddr_r == ADDR_SIG_1)
                vfy_byte = SIG_BYTE_1;
        end
        else if (!has_code && (var_r != VAR_MASK))
            vfy_byte = ERASED_BYTE;
        else if (vmode_r == MODE_VFY_CODE)
        begin
            if ((lvl < 2'd2) && (vaddr_r <= ADDR_CODE_LAST))
                vfy_byte = ~(code_rd ^ key_rd);
        end
        else if (vmode_r == MODE_VFY_CFG)
        begin
            if (vaddr_r == ADDR_CFG_LOW)
                vfy_byte = cfg_lo_r;
            else if (vaddr_r == ADDR_CFG_HIGH)
                vfy_byte = cfg_hi_r;
        end
        else if (vmode_r == MODE_VFY_LOCK)
            vfy_byte = {5'b00000, lock_r};
    end

    // Stage two drives port two; key verify falls to the erased default.
    always_ff @(posedge MCLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            PORT_TWO_DATA_O    <= 8'h00;
            PORT_TWO_DATA_OE_O <= 1'b0;
        end
        else if (CE_I)
        begin
            PORT_TWO_DATA_O    <= vfy_v_r ? vfy_byte : 8'h00;
            PORT_TWO_DATA_OE_O <= vfy_v_r;
        end
    end

    // ****************************************************************
    // Status and permissions
    // ****************************************************************
    // Registered so that every permission seen by the core comes from a flop.
    always_ff @(posedge MCLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            LOCK_LEVEL_O         <= 2'd0;
            LOCK_LEVEL_BITS_O    <= LOCK_RST;
            CONFIG_BYTE_LOW_O    <= CFG_RST;
            CONFIG_BYTE_HIGH_O   <= CFG_RST;
            INT_EXEC_EN_O        <= 1'b0;
            EXT_EXEC_EN_O        <= 1'b0;
            CODE_TABLE_READ_EN_O <= 1'b0;
            PROG_DONE_O          <= 1'b0;
            PROG_REFUSED_O       <= 1'b0;
        end
        else if (CE_I)
        begin
            LOCK_LEVEL_O         <= lvl;
            LOCK_LEVEL_BITS_O    <= lock_r;
            CONFIG_BYTE_LOW_O    <= cfg_lo_r;
            CONFIG_BYTE_HIGH_O   <= cfg_hi_r;
            INT_EXEC_EN_O        <= 1'b1;
            EXT_EXEC_EN_O        <= (lvl != 2'd3);
            CODE_TABLE_READ_EN_O <= (lvl == 2'd0);
            PROG_DONE_O          <= any_we;
            PROG_REFUSED_O       <= commit && !any_we;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!ARST_N_I || !CE_I);

    a_single_write: assert property (commit |=> !commit [*8])
        else $error("Second write inside one pulse.");
    a_lock_blocks_prog: assert property (commit && lvl != 2'd0 && req.mode != MODE_PRG_LOCK
        |=> PROG_REFUSED_O && !PROG_DONE_O)
        else $error("Programming accepted while locked.");
    a_mask_no_prog: assert property (commit && var_r == VAR_MASK
        |=> PROG_REFUSED_O && !PROG_DONE_O)
        else $error("Mask variant accepted a write.");
    a_key_hidden: assert property (vfy_sel && req.mode == MODE_VFY_KEY |-> ##2 PORT_TWO_DATA_O == 8'hFF)
        else $error("Key array leaked on verify.");
    a_lock_readback: assert property (vfy_sel && req.mode == MODE_VFY_LOCK && !lock_we
        |-> ##2 PORT_TWO_DATA_O[2:0] == $past(lock_r, 1))
        else $error("Lock verify value wrong.");
    a_code_scramble: assert property (vfy_v_r && vmode_r == MODE_VFY_CODE && lvl < 2'd2 && has_code
        && vaddr_r <= ADDR_CODE_LAST |=> PORT_TWO_DATA_O == ~($past(code_rd) ^ $past(key_rd)))
        else $error("Code verify not XNOR of key.");
    a_level2_hides: assert property (vfy_v_r && vmode_r == MODE_VFY_CODE && lvl >= 2'd2
        |=> PORT_TWO_DATA_O == 8'hFF)
        else $error("Code visible at level two.");
    a_port_drive: assert property (vfy_sel |-> ##2 PORT_TWO_DATA_OE_O)
        else $error("Port two not driven in verify.");
    a_ext_exec: assert property (lvl == 2'd3 |=> !EXT_EXEC_EN_O && INT_EXEC_EN_O)
        else $error("External execution open at level three.");

    c_code_write: cover property (code_we);
    c_lock_set: cover property (lock_we ##1 lvl != 2'd0);
    c_code_verify: cover property (vfy_sel && req.mode == MODE_VFY_CODE ##2 PORT_TWO_DATA_OE_O);
    c_refused: cover property (commit && !any_we);

endmodule

// ### logic/nvpl_pkg.sv
// Shared constants, types and lock decoding for the memory programming and verify path.
package nvpl_pkg;

    // ****************************************************************
    // Mode codes applied on port zero
    // ****************************************************************
    localparam logic [7:0]  MODE_PRG_CODE  = 8'h68;
    localparam logic [7:0]  MODE_PRG_CFG   = 8'h69;
    localparam logic [7:0]  MODE_PRG_LOCK  = 8'h6B;
    localparam logic [7:0]  MODE_PRG_KEY   = 8'h6C;
    localparam logic [7:0]  MODE_VFY_CODE  = 8'h28;
    localparam logic [7:0]  MODE_VFY_CFG   = 8'h29;
    localparam logic [7:0]  MODE_VFY_LOCK  = 8'h2B;
    localparam logic [7:0]  MODE_VFY_KEY   = 8'h2C;
    localparam logic [7:0]  MODE_VFY_SIG   = 8'h2E;

    // ****************************************************************
    // Address map
    // ****************************************************************
    localparam logic [15:0] ADDR_CODE_LAST = 16'h7FFF;
    localparam logic [15:0] ADDR_KEY_LAST  = 16'h007F;
    localparam logic [15:0] ADDR_CFG_LOW   = 16'hFFF8;
    localparam logic [15:0] ADDR_CFG_HIGH  = 16'hFFF9;
    localparam logic [15:0] ADDR_LB0       = 16'h0001;
    localparam logic [15:0] ADDR_LB1       = 16'h0002;
    localparam logic [15:0] ADDR_LB2       = 16'h0003;
    localparam logic [15:0] ADDR_SIG_0     = 16'h0030;
    localparam logic [15:0] ADDR_SIG_1     = 16'h0031;
    localparam int          CODE_DEPTH     = 32768;
    localparam int          CODE_AW        = 15;
    localparam int          KEY_DEPTH      = 128;
    localparam int          KEY_AW         = 7;

    // ****************************************************************
    // Reset and fixed contents
    // ****************************************************************
    localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
    localparam logic [7:0]  CFG_RST        = 8'hFF;
    localparam logic [2:0]  LOCK_RST       = 3'b000;
    localparam logic [7:0]  SIG_BYTE_0     = 8'h5A;  // Arbitrary value.
    localparam logic [7:0]  SIG_BYTE_1     = 8'hC3;  // Arbitrary value.

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int          PROG_PULSE_US  = 100;
    localparam int          CLK_MHZ        = 125;
    localparam int          PROG_PULSE_CYC = PROG_PULSE_US * CLK_MHZ;
    localparam int          PCNT_W         = 16;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        VAR_EPROM   = 2'b00,
        VAR_OTP     = 2'b01,
        VAR_MASK    = 2'b10,
        VAR_ROMLESS = 2'b11
    } nvpl_var_t;

    typedef enum logic [1:0] {
        PST_IDLE  = 2'b00,
        PST_PULSE = 2'b01,
        PST_HOLD  = 2'b10
    } nvpl_pst_t;

    typedef struct packed {
        logic [7:0]  mode;
        logic [15:0] addr;
        logic [7:0]  data;
    } nvpl_req_t;

    // Highest programmed lock bit wins; the mask part knows only the first level.
    function automatic logic [1:0] lock_level(input logic [2:0] lb, input nvpl_var_t v);
        logic [1:0] lvl;
        lvl = 2'd0;
        if (v == VAR_MASK)
            lvl = lb[0] ? 2'd1 : 2'd0;
        else if (lb[2])
            lvl = 2'd3;
        else if (lb[1])
            lvl = 2'd2;
        else if (lb[0])
            lvl = 2'd1;
        return lvl;
    endfunction

endpackage

// ### logic/nvpl_mem.sv
// Byte memory whose writes can only clear bits, with registered read data.
`timescale 1ns/100ps
module nvpl_mem
#(
    parameter int DEPTH = 128,
    parameter int AW    = 7
)
(
    input  wire logic          clk_i,
    input  wire logic          ce_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [7:0]    wdata_i,
    output logic      [7:0]    rdata_o
);

    logic [7:0] mem [DEPTH];

    // Cells start erased; this stands for a part that left the factory blank.
    initial
    begin
        for (int i = 0; i < DEPTH; i++)
            mem[i] = 8'hFF;
    end

    // A write merges by AND, so a zero bit is never turned back to one.
    always_ff @(posedge clk_i)
    begin
        if (ce_i)
        begin
            if (we_i)
                mem[addr_i] <= mem[addr_i] & wdata_i;
            rdata_o <= mem[addr_i];
        end
    end

endmodule

// ### testbench/nvpl_prog_model.sv
// Behavioural programmer that drives the pins of the programming and verify path.
`timescale 1ns/100ps
module nvpl_prog_model
#(
    parameter int PULSE_CYC = 4
)
(
    input  wire logic       clk_i,
    input  wire logic       done_i,
    input  wire logic       refused_i,
    input  wire logic [7:0] p2_i,
    input  wire logic       p2_oe_i,
    output logic            rst_pin_o,
    output logic            strobe_n_o,
    output logic            latch_n_o,
    output logic            supply_o,
    output logic      [7:0] p0_o,
    output logic      [7:0] p1_o,
    output logic      [7:0] p3_o,
    output logic      [7:0] p2_o,
    output logic            p2_en_o
);
    // The chip stays in reset for the whole run, strobe and latch idle high, supply low.
    initial
    begin
        rst_pin_o  = 1'b1;
        strobe_n_o = 1'b1;
        latch_n_o  = 1'b1;
        supply_o   = 1'b0;
        p0_o       = 8'hFF;
        p1_o       = 8'h00;
        p3_o       = 8'h00;
        p2_o       = 8'h00;
        p2_en_o    = 1'b0;
    end

    // Ends a sequence by releasing strobe, latch and mode lines.
    task automatic idle();
        @(negedge clk_i);
        strobe_n_o = 1'b1;
        latch_n_o  = 1'b1;
        supply_o   = 1'b0;
        p0_o       = 8'hFF;
        p2_en_o    = 1'b0;
    endtask

    // One pulse held for n cycles; done and refused pulses are counted until it settles.
    task automatic prog(input logic [7:0] mode, input logic [15:0] addr,
                        input logic [7:0] data, input int n, output int nd, output int nr);
        nd = 0;
        nr = 0;
        @(negedge clk_i);
        {p0_o, p1_o, p3_o, p2_o} = {mode, addr, data};
        strobe_n_o = 1'b0;
        supply_o   = 1'b1;
        p2_en_o    = 1'b1;
        latch_n_o  = 1'b0;
        for (int i = 0; i < n + 4; i++)
        begin
            @(negedge clk_i);
            nd += int'(done_i === 1'b1);
            nr += int'(refused_i === 1'b1);
            if (i == n - 1)
                latch_n_o = 1'b1;
        end
    endtask

    // Read with latency two; from idle the strobe falls two cycles after controls go high.
    task automatic vfy(input logic [7:0] mode, input logic [15:0] addr,
                       output logic [7:0] data, output logic oe);
        @(negedge clk_i);
        if (strobe_n_o === 1'b1)
            repeat (2) @(negedge clk_i);
        strobe_n_o = 1'b0;
        latch_n_o  = 1'b1;
        supply_o   = 1'b0;
        p2_en_o    = 1'b0;
        {p0_o, p1_o, p3_o} = {mode, addr};
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        data = p2_i;
        oe   = p2_oe_i;
    endtask
endmodule

// ### testbench/testbench.sv
// Self-checking bench for the programming and verify path.
`timescale 1ns/100ps
module testbench;
    import nvpl_pkg::*;
    localparam int P     = 4;
    localparam int LONG  = P + 4;
    localparam int SHORT = P - 1;
    localparam logic [7:0] ST_TAB [3] = '{8'h19, 8'h1A, 8'h13};
    localparam logic [7:0] LK_TAB [3] = '{8'h01, 8'h03, 8'h07};
    localparam logic [7:0] CD_TAB [3] = '{8'h2B, 8'hFF, 8'hFF};
    logic       clk = 1'b0;
    logic       arst_n = 1'b0;
    logic       ce = 1'b1;
    logic [1:0] variant = 2'b00;
    logic       rst_pin, strobe_n, latch_n, supply, p2en, doe, int_en, ext_en, tbl_en;
    logic       done, refused;
    logic [7:0] p0, p1, p3, p2m, p2w, dout, cfg_lo, cfg_hi, st;
    logic [1:0] lvl;
    logic [2:0] lbits;
    int         err_count = 0;
    int         num_checks = 0;

    // ****************************************************************
    // Clock, port two wire and instances
    // ****************************************************************
    initial
        forever #4 clk = ~clk;
    // A released line shows the inverse of the last driven value, never a stale copy.
    assign p2w = doe ? dout : (p2en ? p2m : ~p2m);
    assign st  = {3'b000, int_en, ext_en, tbl_en, lvl};

    nvpl_top #(.PULSE_CYC(P)) uut (.MCLK_I(clk), .ARST_N_I(arst_n), .CE_I(ce),
        .VARIANT_I(variant), .CHIP_RESET_I(rst_pin), .CODE_FETCH_STROBE_N_I(strobe_n),
        .ADDR_LATCH_PROG_PULSE_N_I(latch_n), .EXT_ACCESS_PROG_SUPPLY_I(supply),
        .PORT_ZERO_I(p0), .PORT_ONE_ADDR_HIGH_I(p1), .PORT_THREE_ADDR_LOW_I(p3),
        .PORT_TWO_DATA_I(p2w), .PORT_TWO_DATA_O(dout), .PORT_TWO_DATA_OE_O(doe),
        .LOCK_LEVEL_O(lvl), .LOCK_LEVEL_BITS_O(lbits), .CONFIG_BYTE_LOW_O(cfg_lo),
        .CONFIG_BYTE_HIGH_O(cfg_hi), .INT_EXEC_EN_O(int_en), .EXT_EXEC_EN_O(ext_en),
        .CODE_TABLE_READ_EN_O(tbl_en), .PROG_DONE_O(done), .PROG_REFUSED_O(refused));

    nvpl_prog_model #(.PULSE_CYC(P)) pm (.clk_i(clk), .done_i(done), .refused_i(refused),
        .p2_i(p2w), .p2_oe_i(doe), .rst_pin_o(rst_pin), .strobe_n_o(strobe_n),
        .latch_n_o(latch_n), .supply_o(supply), .p0_o(p0), .p1_o(p1), .p3_o(p3),
        .p2_o(p2m), .p2_en_o(p2en));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // A verify must drive port two and return the expected byte.
    task automatic rd(input logic [7:0] mode, input logic [15:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic       oe;
        pm.vfy(mode, addr, d, oe);
        chk("verify_oe", {7'h00, oe}, 8'h01);
        chk("verify_data", d, exp);
    endtask

    // A pulse must give exactly the expected number of done and refused pulses.
    task automatic wr(input logic [7:0] mode, input logic [15:0] addr, input logic [7:0] data,
                      input int n, input logic [7:0] ed, input logic [7:0] er);
        int nd;
        int nr;
        pm.prog(mode, addr, data, n, nd, nr);
        chk("prog_done", 8'(nd), ed);
        chk("prog_refused", 8'(nr), er);
    endtask

    // Reset holds twelve cycles; the strap is in by the second edge after release.
    task automatic do_reset(input logic [1:0] v);
        @(negedge clk);
        arst_n  = 1'b0;
        variant = v;
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        repeat (2) @(negedge clk);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        do_reset(VAR_EPROM);
        chk("status", st, 8'h1C);
        chk("cfg_low", cfg_lo, CFG_RST);
        chk("lock_bits", {5'h00, lbits}, {5'h00, LOCK_RST});
        rd(MODE_VFY_CODE, 16'h0010, ERASED_BYTE);
        wr(MODE_PRG_CODE, 16'h0010, 8'hA5, LONG, 8'h01, 8'h00);
        rd(MODE_VFY_CODE, 16'h0010, 8'hA5);
        wr(MODE_PRG_CODE, 16'h0010, 8'h3C, LONG, 8'h01, 8'h00);
        rd(MODE_VFY_CODE, 16'h0010, 8'h24);
        // With the clock enable low a full pulse must write nothing and report nothing.
        ce = 1'b0;
        wr(MODE_PRG_CODE, 16'h0010, 8'h00, LONG, 8'h00, 8'h00);
        ce = 1'b1;
        rd(MODE_VFY_CODE, 16'h0010, 8'h24);
        wr(MODE_PRG_CODE, ADDR_CODE_LAST, 8'h00, SHORT, 8'h00, 8'h00);
        rd(MODE_VFY_CODE, ADDR_CODE_LAST, ERASED_BYTE);
        wr(MODE_PRG_CODE, 16'h8000, 8'h00, LONG, 8'h00, 8'h01);
        wr(MODE_PRG_KEY, ADDR_KEY_LAST, 8'hFF, LONG, 8'h01, 8'h00);
        wr(MODE_PRG_KEY, 16'h0010, 8'hF0, LONG, 8'h01, 8'h00);
        wr(MODE_PRG_KEY, 16'h0080, 8'h00, LONG, 8'h00, 8'h01);
        rd(MODE_VFY_CODE, 16'h0010, ~(8'h24 ^ 8'hF0));
        rd(MODE_VFY_CODE, 16'h0090, ~(ERASED_BYTE ^ 8'hF0));
        rd(MODE_VFY_KEY, 16'h0010, ERASED_BYTE);
        wr(MODE_PRG_CFG, ADDR_CFG_LOW, 8'h7E, LONG, 8'h01, 8'h00);
        wr(MODE_PRG_CFG, ADDR_CFG_HIGH, 8'hBD, LONG, 8'h01, 8'h00);
        chk("cfg_low", cfg_lo, 8'h7E);
        chk("cfg_high", cfg_hi, 8'hBD);
        wr(MODE_VFY_SIG, ADDR_SIG_0, 8'h00, LONG, 8'h00, 8'h01);
        rd(MODE_VFY_SIG, ADDR_SIG_0, SIG_BYTE_0);
        for (int i = 0; i < 3; i++)
        begin
            wr(MODE_PRG_LOCK, ADDR_LB0 + 16'(i), 8'h00, LONG, 8'h01, 8'h00);
            chk("status", st, ST_TAB[i]);
            rd(MODE_VFY_LOCK, 16'h0000, LK_TAB[i]);
            wr(MODE_PRG_CODE, 16'h0020, 8'h00, LONG, 8'h00, 8'h01);
            wr(MODE_PRG_CFG, ADDR_CFG_LOW, 8'h00, LONG, 8'h00, 8'h01);
            wr(MODE_PRG_KEY, 16'h0020, 8'h00, LONG, 8'h00, 8'h01);
            rd(MODE_VFY_CODE, 16'h0010, CD_TAB[i]);
            rd(MODE_VFY_CFG, ADDR_CFG_LOW, 8'h7E);
        end
        pm.idle();
        do_reset(VAR_EPROM);
        rd(MODE_VFY_CODE, 16'h0020, ERASED_BYTE);
        wr(MODE_PRG_LOCK, ADDR_LB2, 8'h00, LONG, 8'h01, 8'h00);
        chk("status", st, 8'h13);
        rd(MODE_VFY_CODE, 16'h0010, ERASED_BYTE);
        wr(MODE_PRG_CODE, 16'h0040, 8'h00, LONG, 8'h00, 8'h01);
        pm.idle();
        do_reset(VAR_MASK);
        wr(MODE_PRG_CODE, 16'h0040, 8'h00, LONG, 8'h00, 8'h01);
        wr(MODE_PRG_LOCK, ADDR_LB0, 8'h00, LONG, 8'h00, 8'h01);
        rd(MODE_VFY_CODE, 16'h0010, 8'h2B);
        pm.idle();
        do_reset(VAR_ROMLESS);
        rd(MODE_VFY_CODE, 16'h0010, ERASED_BYTE);
        rd(MODE_VFY_SIG, ADDR_SIG_1, SIG_BYTE_1);
        pm.idle();
        finish_test();
    end

    // A hang is cut short and counted as a mismatch.
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        finish_test();
    end
endmodule
